//--- rtl/bm_channel.sv
/*
 * one bus master channel: command and status registers plus the
 * start/stop control of the data mover. the mover itself is outside;
 * it reports descriptor, end-of-table and abort events as 1-cycle pulses
 * on this clock. ide_irq is an asynchronous pin, synchronised here.
 */
`timescale 1ns/10ps
module bm_channel
   import bm_pkg::*;
(
   // clock and reset
   input  wire logic       clock,
   input  wire logic       rstn,
   // register access, already decoded to this channel
   input  wire logic       cmd_wr,
   input  wire logic       sts_wr,
   input  wire logic [7:0] wdata,
   // platform inputs
   input  wire logic       bus_master_en,
   input  wire logic       ide_irq,
   // events from the data mover
   input  wire logic       desc_done,
   input  wire logic       descriptor_irq_flag,
   input  wire logic       last_region_marker,
   input  wire logic       pci_abort,
   // register views and engine control
   output logic [7:0]      cmd_q,
   output logic [7:0]      sts_q,
   output logic            xfer_go,
   output logic            xfer_dir,
   output logic            xfer_flush,
   output logic            xfer_abort
);
   typedef struct packed {
      logic [7:0] cmd;
      logic [7:0] sts;
      eng_state_t st;
      logic [1:0] irq_sync;
      logic       irq_prev;
      logic       go;
      logic       dir;
      logic       flush;
      logic       abort;
   } ch_state_t;

   ch_state_t s_reg;
   ch_state_t s_next;
   logic      run_rise;
   logic      run_fall;
   logic      irq_edge;

   // ==========================================================
   // next state
   always_comb begin
      s_next = s_reg;
      s_next.irq_sync = {s_reg.irq_sync[0], ide_irq};
      s_next.irq_prev = s_reg.irq_sync[1];
      irq_edge = s_reg.irq_sync[1] & ~s_reg.irq_prev;
      run_rise = cmd_wr & wdata[CMD_RUN_BIT] & ~s_reg.cmd[CMD_RUN_BIT];
      run_fall = cmd_wr & ~wdata[CMD_RUN_BIT] & s_reg.cmd[CMD_RUN_BIT];
      s_next.flush = 1'b0;
      s_next.abort = 1'b0;
      // only run and direction are writable; hardware never clears run
      if (cmd_wr) begin
         s_next.cmd = wdata & 8'h09;
      end
      // status: w1c flags first, so a same-cycle event below wins
      if (sts_wr) begin
         s_next.sts[STS_CAP1_BIT] = wdata[STS_CAP1_BIT];
         s_next.sts[STS_CAP0_BIT] = wdata[STS_CAP0_BIT];
         if (wdata[STS_DESC_BIT]) s_next.sts[STS_DESC_BIT] = 1'b0;
         if (wdata[STS_IRQ_BIT])  s_next.sts[STS_IRQ_BIT] = 1'b0;
         if (wdata[STS_ERR_BIT])  s_next.sts[STS_ERR_BIT] = 1'b0;
      end
      if (irq_edge) s_next.sts[STS_IRQ_BIT] = 1'b1;
      if (s_reg.go && pci_abort) begin
         s_next.sts[STS_ERR_BIT] = 1'b1;
      end
      if (s_reg.go && desc_done && descriptor_irq_flag) begin
         s_next.sts[STS_DESC_BIT] = 1'b1;
      end
      // engine sequencing
      unique case (s_reg.st)
         ST_IDLE: begin
            if (run_rise) begin
               s_next.st = ST_RUN;
               s_next.sts[STS_ACT_BIT] = 1'b1;
               s_next.dir = wdata[CMD_DIR_BIT];
            end
         end
         ST_RUN: begin
            if (run_fall) begin
               s_next.st = ST_IDLE;
               s_next.sts[STS_ACT_BIT] = 1'b0;
               s_next.flush = 1'b1;
               // stopped before the drive raised its interrupt
               s_next.abort = ~s_reg.sts[STS_IRQ_BIT];
            end else if (s_reg.go && desc_done && last_region_marker) begin
               s_next.st = ST_DONE;
               s_next.sts[STS_ACT_BIT] = 1'b0;
            end
         end
         ST_DONE: begin
            // waits here until software drops run; no resume
            if (run_fall) begin
               s_next.st = ST_IDLE;
               s_next.flush = 1'b1;
            end
         end
         default: s_next.st = ST_IDLE;
      endcase
      // mover runs only in run state, with pci mastering allowed
      s_next.go = (s_next.st == ST_RUN) & bus_master_en;
   end

   // ==========================================================
   // state register
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         s_reg <= '{cmd: CMD_RESET & 8'h08, sts: STS_RESET,
                    st: ST_IDLE, irq_sync: 2'b00, irq_prev: 1'b0,
                    go: 1'b0, dir: 1'b0, flush: 1'b0, abort: 1'b0};
      end else begin
         s_reg <= s_next;
      end
   end

   assign cmd_q      = s_reg.cmd;
   assign sts_q      = s_reg.sts;
   assign xfer_go    = s_reg.go;
   assign xfer_dir   = s_reg.dir;
   assign xfer_flush = s_reg.flush;
   assign xfer_abort = s_reg.abort;
endmodule

//--- rtl/bm_pkg.sv
/*
 * constants shared by the bus master control/status block: byte offsets in
 * the 16-byte i/o window, bit positions and reset values (the command register loads CMD_RESET & 8'h08).
 * assumes an 8-bit i/o register port with byte address and strobes.
 */
package bm_pkg;
   // ==========================================================
   // register offsets
   localparam logic [3:0] OFF_CMD_PRI  = 4'h0;
   localparam logic [3:0] OFF_STS_PRI  = 4'h2;
   localparam logic [3:0] OFF_CMD_SEC  = 4'h8;
   localparam logic [3:0] OFF_STS_SEC  = 4'hA;
   // ==========================================================
   // command register fields
   localparam int CMD_RUN_BIT = 0;
   localparam int CMD_DIR_BIT = 3;
   localparam logic [7:0] CMD_RESET = 8'h01;
   // ==========================================================
   // status register fields
   localparam int STS_ACT_BIT  = 0;
   localparam int STS_ERR_BIT  = 1;
   localparam int STS_IRQ_BIT  = 2;
   localparam int STS_CAP0_BIT = 5;
   localparam int STS_CAP1_BIT = 6;
   localparam int STS_DESC_BIT = 7;
   localparam logic [7:0] STS_RESET = 8'h00;
   // ==========================================================
   // engine states, gray along idle->run->done
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_RUN  = 2'b01,
      ST_DONE = 2'b11
   } eng_state_t;
endpackage

//--- rtl/bm_ctrl_status.sv
/*
 * bus master control/status for two ide channels behind an 8-bit i/o
 * register port (byte address within a 16-byte window, write and read
 * strobes). the data movers sit outside and obey xfer_go_*.
 */
`timescale 1ns/10ps
module bm_ctrl_status
   import bm_pkg::*;
(
   // clock and reset
   input  wire logic       clock,
   input  wire logic       rstn,
   // i/o register port
   input  wire logic [3:0] io_addr,
   input  wire logic       io_wr,
   input  wire logic       io_rd,
   input  wire logic [7:0] io_wdata,
   output logic [7:0]      io_rdata,
   // pci configuration
   input  wire logic       bus_master_en,
   // ide interrupt pins
   input  wire logic       ide_irq_pri,
   input  wire logic       ide_irq_sec,
   // primary mover events
   input  wire logic       desc_done_pri,
   input  wire logic       desc_irq_flag_pri,
   input  wire logic       last_region_pri,
   input  wire logic       pci_abort_pri,
   // secondary mover events
   input  wire logic       desc_done_sec,
   input  wire logic       desc_irq_flag_sec,
   input  wire logic       last_region_sec,
   input  wire logic       pci_abort_sec,
   // primary mover control
   output logic            xfer_go_pri,
   output logic            xfer_dir_pri,
   output logic            xfer_flush_pri,
   output logic            xfer_abort_pri,
   // secondary mover control
   output logic            xfer_go_sec,
   output logic            xfer_dir_sec,
   output logic            xfer_flush_sec,
   output logic            xfer_abort_sec
);
   // all flops of the top level: enable synchroniser and read data
   typedef struct packed {
      logic       bme_s1;
      logic       bme_s2;
      logic [7:0] rdata;
   } top_state_t;

   top_state_t t_reg;
   top_state_t t_next;
   logic [7:0] cmd_p;
   logic [7:0] sts_p;
   logic [7:0] cmd_s;
   logic [7:0] sts_s;

   bm_channel u_pri (
      .clock(clock), .rstn(rstn),
      .cmd_wr(io_wr && io_addr == OFF_CMD_PRI),
      .sts_wr(io_wr && io_addr == OFF_STS_PRI),
      .wdata(io_wdata), .bus_master_en(t_reg.bme_s2),
      .ide_irq(ide_irq_pri),
      .desc_done(desc_done_pri), .descriptor_irq_flag(desc_irq_flag_pri),
      .last_region_marker(last_region_pri), .pci_abort(pci_abort_pri),
      .cmd_q(cmd_p), .sts_q(sts_p), .xfer_go(xfer_go_pri),
      .xfer_dir(xfer_dir_pri), .xfer_flush(xfer_flush_pri),
      .xfer_abort(xfer_abort_pri)
   );

   bm_channel u_sec (
      .clock(clock), .rstn(rstn),
      .cmd_wr(io_wr && io_addr == OFF_CMD_SEC),
      .sts_wr(io_wr && io_addr == OFF_STS_SEC),
      .wdata(io_wdata), .bus_master_en(t_reg.bme_s2),
      .ide_irq(ide_irq_sec),
      .desc_done(desc_done_sec), .descriptor_irq_flag(desc_irq_flag_sec),
      .last_region_marker(last_region_sec), .pci_abort(pci_abort_sec),
      .cmd_q(cmd_s), .sts_q(sts_s), .xfer_go(xfer_go_sec),
      .xfer_dir(xfer_dir_sec), .xfer_flush(xfer_flush_sec),
      .xfer_abort(xfer_abort_sec)
   );

   // ==========================================================
   // enable comes from config space, treated as async: two flops.
   // read mux; unmapped bytes read zero, data held until next read
   always_comb begin
      t_next = t_reg;
      t_next.bme_s1 = bus_master_en;
      t_next.bme_s2 = t_reg.bme_s1;
      if (io_rd) begin
         unique case (io_addr)
            OFF_CMD_PRI: t_next.rdata = cmd_p;
            OFF_STS_PRI: t_next.rdata = sts_p;
            OFF_CMD_SEC: t_next.rdata = cmd_s;
            OFF_STS_SEC: t_next.rdata = sts_s;
            default:     t_next.rdata = 8'h00;
         endcase
      end
   end

   // ==========================================================
   // state register
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         t_reg <= '{bme_s1: 1'b0, bme_s2: 1'b0, rdata: 8'h00};
      end else begin
         t_reg <= t_next;
      end
   end

   assign io_rdata = t_reg.rdata;
endmodule

//--- verification/bm_ctrl_status_properties.sv
/* checker on the top ports of the control/status block.
   assumes one clock and the async active-low reset. */
`timescale 1ns/10ps
module bm_ctrl_status_properties
   import bm_pkg::*;
(
   // clock and reset
   input wire logic       clock,
   input wire logic       rstn,
   // register port
   input wire logic [3:0] io_addr,
   input wire logic       io_wr,
   input wire logic       io_rd,
   input wire logic [7:0] io_wdata,
   input wire logic [7:0] io_rdata,
   input wire logic       bus_master_en,
   // primary mover side
   input wire logic       desc_done_pri,
   input wire logic       last_region_pri,
   input wire logic       xfer_go_pri,
   input wire logic       xfer_dir_pri,
   input wire logic       xfer_flush_pri,
   input wire logic       xfer_abort_pri
);
   default clocking @(posedge clock); endclocking
   default disable iff (!rstn);
   logic cw;
   logic run_reg;
   // run bit as software wrote it; a rewrite of 1 is no start
   assign cw = io_wr && io_addr == OFF_CMD_PRI;
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) run_reg <= 1'b0;
      else if (cw) run_reg <= io_wdata[0];
   end
   // ======================================================
   // start and stop
   chk_start_go: assert property (
      cw && io_wdata[0] && !run_reg && bus_master_en
      && $past(bus_master_en, 2) |=> xfer_go_pri) else $error("no start");
   chk_no_start: assert property (
      !xfer_go_pri && !(cw && io_wdata[0] && !run_reg) |=> !xfer_go_pri)
      else $error("spurious start");
   chk_stop_flush: assert property (
      cw && !io_wdata[0] && xfer_go_pri |=> xfer_flush_pri && !xfer_go_pri)
      else $error("stop lost");
   chk_abort_flush: assert property (
      xfer_abort_pri |-> xfer_flush_pri) else $error("abort alone");
   chk_go_holds: assert property (
      xfer_go_pri && !cw && !(desc_done_pri && last_region_pri)
      |=> xfer_go_pri) else $error("go dropped");
   chk_end_stop: assert property (
      xfer_go_pri && desc_done_pri && last_region_pri |=> !xfer_go_pri)
      else $error("end ignored");
   chk_dir_start: assert property (
      $rose(xfer_go_pri) && $past(cw)
      |-> xfer_dir_pri == $past(io_wdata[3]))
      else $error("direction");
   chk_sts_read: assert property (
      io_rd && io_addr == OFF_STS_PRI && xfer_go_pri && !cw
      |=> io_rdata[0] && io_rdata[4:3] == 2'b00) else $error("status");
endmodule
bind bm_ctrl_status bm_ctrl_status_properties chk (.clock, .rstn,
   .io_addr, .io_wr, .io_rd, .io_wdata, .io_rdata, .bus_master_en,
   .desc_done_pri, .last_region_pri, .xfer_go_pri, .xfer_dir_pri,
   .xfer_flush_pri, .xfer_abort_pri);

//--- verification/bm_mover_model.sv
/* stand-in for one data mover: on a request it waits LAT cycles and
   reports one event. assumes the block's clock and reset. */
`timescale 1ns/10ps
module bm_mover_model #(
   parameter int LAT = 4
) (
   // clock, reset and run level
   input  wire logic       clock,
   input  wire logic       rstn,
   input  wire logic       go,
   // request: bit0 irq flag, bit1 last region, bit2 abort
   input  wire logic       fire,
   input  wire logic [2:0] kind,
   // event pulses
   output logic [3:0]      ev
);
   logic [3:0] cnt;
   // ======================================================
   // a stopped mover reports nothing, like the real one
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         cnt <= 4'h0;
         ev <= 4'h0;
      end else begin
         ev <= 4'h0;
         if (fire) begin
            cnt <= 4'(LAT);
         end else if (cnt != 4'h0) begin
            cnt <= cnt - 4'h1;
            if (cnt == 4'h1 && go) begin
               ev <= {!kind[2], kind};
            end
         end
      end
   end
endmodule

//--- verification/bm_ctrl_status_test.sv
/* bench: register tasks, mover model on primary, pulse monitors.
   assumes a 50 MHz clock and async active-low reset. */
`timescale 1ns/10ps
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin \
   fail_count++; $display("ERROR %0t: got %h exp %h", $time, a, e); end end
module bm_ctrl_status_test
   import bm_pkg::*;
;
   logic clock = 1'b0, rstn = 1'b0, io_wr = 1'b0, io_rd = 1'b0;
   logic bus_master_en = 1'b1, ide_irq_pri = 1'b0, ide_irq_sec = 1'b0;
   logic fire = 1'b0;
   logic [3:0] io_addr = 4'h0;
   logic [7:0] io_wdata = 8'h00;
   logic [7:0] io_rdata;
   logic [2:0] kind = 3'h0;
   logic [3:0] ev;
   logic xfer_go_pri, xfer_dir_pri, xfer_flush_pri, xfer_abort_pri;
   logic xfer_go_sec, xfer_dir_sec, xfer_flush_sec, xfer_abort_sec;
   int fail_count = 0, num_checks = 0, cycles = 0;
   int n_flush = 0, n_abort = 0, n_fsec = 0, n_asec = 0;
   always #10 clock = ~clock;
   bm_mover_model #(.LAT(4)) mover (.clock, .rstn, .go(xfer_go_pri),
      .fire, .kind, .ev);
   bm_ctrl_status DUT (.clock, .rstn, .io_addr, .io_wr, .io_rd,
      .io_wdata, .io_rdata, .bus_master_en, .ide_irq_pri, .ide_irq_sec,
      .desc_done_pri(ev[3]), .desc_irq_flag_pri(ev[0]),
      .last_region_pri(ev[1]), .pci_abort_pri(ev[2]),
      .desc_done_sec(1'b0), .desc_irq_flag_sec(1'b0),
      .last_region_sec(1'b0), .pci_abort_sec(1'b0), .xfer_go_pri,
      .xfer_dir_pri, .xfer_flush_pri, .xfer_abort_pri, .xfer_go_sec,
      .xfer_dir_sec, .xfer_flush_sec, .xfer_abort_sec);
   task automatic wrap_up();
      if (fail_count == 0 && num_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clock) #1;
      {io_addr, io_wdata, io_wr} = {a, d, 1'b1};
      @(posedge clock) #1;
      io_wr = 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [7:0] e);
      @(posedge clock) #1;
      {io_addr, io_rd} = {a, 1'b1};
      @(posedge clock) #1;
      io_rd = 1'b0;
      @(posedge clock) #1;
      `CHK(io_rdata, e)
   endtask
   task automatic mv(input logic [2:0] k);
      @(posedge clock) #1;
      {kind, fire} = {k, 1'b1};
      @(posedge clock) #1;
      fire = 1'b0;
      repeat (8) @(posedge clock);
   endtask
   // one-cycle pulses are counted, so every stop is seen; a hang ends
   always @(posedge clock) begin
      cycles++;
      if (xfer_flush_pri) n_flush++;
      if (xfer_abort_pri) n_abort++;
      if (xfer_flush_sec) n_fsec++;
      if (xfer_abort_sec) n_asec++;
      if (cycles == 3000) begin
         fail_count++;
         wrap_up();
      end
   end
   // ======================================================
   // main sequence
   initial begin
      repeat (10) @(posedge clock);
      #1 rstn = 1'b1;
      rd(OFF_STS_PRI, 8'h00);
      rd(OFF_STS_SEC, 8'h00);
      rd(4'h1, 8'h00);
      wr(OFF_STS_PRI, 8'hff);
      rd(OFF_STS_PRI, 8'h60);
      wr(OFF_STS_PRI, 8'h00);
      wr(OFF_CMD_PRI, 8'hf6);
      rd(OFF_CMD_PRI, 8'h00);
      bus_master_en = 1'b0;
      repeat (2) @(posedge clock); // let the two-flop sync see it
      wr(OFF_CMD_PRI, 8'h01);
      `CHK(xfer_go_pri, 1'b0)
      wr(OFF_CMD_PRI, 8'h00);
      bus_master_en = 1'b1;
      repeat (4) @(posedge clock);
      wr(OFF_CMD_PRI, 8'h09);
      `CHK(xfer_dir_pri, 1'b1)
      mv(3'b001);
      wr(OFF_STS_PRI, 8'h00);
      rd(OFF_STS_PRI, 8'h81);
      wr(OFF_STS_PRI, 8'h80);
      mv(3'b100);
      rd(OFF_STS_PRI, 8'h03);
      wr(OFF_STS_PRI, 8'h02);
      mv(3'b010);
      rd(OFF_STS_PRI, 8'h00);
      rd(OFF_CMD_PRI, 8'h09);
      wr(OFF_CMD_PRI, 8'h09);
      `CHK(xfer_go_pri, 1'b0)
      wr(OFF_CMD_PRI, 8'h00);
      wr(OFF_CMD_PRI, 8'h01);
      `CHK(xfer_dir_pri, 1'b0)
      wr(OFF_CMD_PRI, 8'h00);
      @(posedge clock) #1;
      `CHK(n_flush, 3)
      `CHK(n_abort, 2)
      wr(OFF_CMD_PRI, 8'h01);
      ide_irq_pri = 1'b1;
      repeat (3) @(posedge clock); // pin passes two flops, then edge
      rd(OFF_STS_PRI, 8'h05);
      wr(OFF_CMD_PRI, 8'h00);
      @(posedge clock) #1;
      `CHK(n_flush, 4)
      `CHK(n_abort, 2)
      wr(OFF_STS_PRI, 8'h04);
      rd(OFF_STS_PRI, 8'h00);
      wr(OFF_CMD_SEC, 8'h09);
      `CHK({xfer_go_sec, xfer_go_pri}, 2'b10)
      `CHK(xfer_dir_sec, 1'b1)
      wr(OFF_CMD_SEC, 8'h00);
      @(posedge clock) #1;
      `CHK(n_fsec, 1)
      `CHK(n_asec, 1)
      wrap_up();
   end
endmodule
